// ### rtl/bse_pkg.sv
/*
  Shared constants and types for the branch, skip, load and store execution block.
  Assumes one 100 MHz clock domain and an 8-bit data space reached through a ready handshake.
*/
package bse_pkg;
  // Register window offsets, byte addresses on the 12-bit bus
  localparam logic [11:0] BSE_OFF_INSTR = 12'h000;
  localparam logic [11:0] BSE_OFF_CFG = 12'h004;
  localparam logic [11:0] BSE_OFF_FLAGS = 12'h008;
  localparam logic [11:0] BSE_OFF_PC = 12'h00c;
  localparam logic [11:0] BSE_OFF_SP = 12'h010;
  localparam logic [11:0] BSE_OFF_STAT = 12'h014;
  localparam logic [11:0] BSE_OFF_REGS = 12'h080;
  // Status flag bit positions
  localparam int BSE_FC = 0;
  localparam int BSE_FZ = 1;
  localparam int BSE_FN = 2;
  localparam int BSE_FV = 3;
  localparam int BSE_FS = 4;
  localparam int BSE_FH = 5;
  localparam int BSE_FI = 7;
  // Reset values
  localparam logic [15:0] BSE_PC_RST = 16'h0000;
  localparam logic [15:0] BSE_SP_RST = 16'h00ff;
  localparam logic [7:0] BSE_FLAGS_RST = 8'h00;
  // Data space layout
  localparam logic [15:0] BSE_IO_BASE = 16'h0000;
  localparam logic [15:0] BSE_NVM_BASE = 16'h1000;
  // Pointer register indices
  localparam logic [4:0] BSE_PX = 5'h1a;
  localparam logic [4:0] BSE_PY = 5'h1c;
  localparam logic [4:0] BSE_PZ = 5'h1e;
  // Cycle counts with internal RAM
  localparam logic [2:0] BSE_CYC_ONE = 3'h1;
  localparam logic [2:0] BSE_CYC_TAKEN = 3'h2;
  localparam logic [2:0] BSE_CYC_SKIP1 = 3'h2;
  localparam logic [2:0] BSE_CYC_SKIP2 = 3'h3;
  localparam logic [2:0] BSE_CYC_DFETCH = 3'h3;
  localparam logic [2:0] BSE_CYC_LDP = 3'h2;
  localparam logic [2:0] BSE_CYC_DWRITE = 3'h2;
  localparam logic [2:0] BSE_CYC_STP = 3'h1;
  localparam logic [2:0] BSE_CYC_CALL = 3'h3;
  localparam logic [2:0] BSE_CYC_BACK = 3'h4;

  typedef enum logic [3:0] {
    BSE_OP_NONE, BSE_OP_CMP, BSE_OP_EQSKIP, BSE_OP_RSKIP, BSE_OP_ISKIP, BSE_OP_BR,
    BSE_OP_DFETCH, BSE_OP_LDP, BSE_OP_DWRITE, BSE_OP_STP, BSE_OP_CALL, BSE_OP_BACK
  } bse_op_t;

  typedef enum logic [1:0] {BSE_S_IDLE, BSE_S_DEC, BSE_S_RUN} bse_state_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bse_dreq_t;
endpackage

// ### rtl/bse_exec.sv
/*
  Execution engine for compares, skips, flag branches, call/return and data loads/stores,
  with its own register file, program counter, stack pointer and status flags behind APB.
  Assumes a same-clock data-space slave that holds dmem_ready low while it is busy.
*/
`timescale 1ns/1ps
module bse_exec
  import bse_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output bse_dreq_t dmem_req,
  input wire logic [7:0] dmem_rdata,
  input wire logic dmem_ready,
  output logic exec_busy
);
  bse_state_t state_r;
  bse_op_t dop;
  bse_dreq_t dmem_r;
  logic [31:0] instr_r, prdata_r, rd_val;
  logic [15:0] w, k2, pc_r, sp_r, pval, pnew, ea, link_pc, koff, nx_addr, pc_nxt;
  logic [15:0] pop_r;
  logic [7:0] rf_r [32];
  logic [7:0] flags_r, flags_nxt, rdv, rrv, res, rbuf_r, nx_wd, cyc_last_r, tot_r;
  logic [4:0] dd, pidx;
  logic [5:0] q;
  logic [2:0] cnt_r, need, need_eff, skip_len;
  logic [1:0] acc_r, nacc;
  logic two_r, busy_r, pready_r, pslverr_r, nvm_wait_r, stalled_r;
  logic ppost, ppre, cmp_carry, eqv, rbit, brc, nx_we, nidx;
  logic acc_fire, stall, fin, hit, eng_reg, err, wr, launch;
  logic fh, fv, fc, fz;

  assign w = instr_r[15:0];
  assign k2 = instr_r[31:16];
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dmem_req = dmem_r;
  assign exec_busy = busy_r;

  // Instruction decode
  always_comb begin
    dop = BSE_OP_NONE;
    pidx = BSE_PZ;
    ppost = 1'b0;
    ppre = 1'b0;
    q = 6'h00;
    casez (w)
      16'b0001_00??_????_????: dop = BSE_OP_EQSKIP;
      16'b0001_01??_????_????, 16'b0000_01??_????_????, 16'b0011_????_????_????: begin
        dop = BSE_OP_CMP;
      end
      16'b1111_11??_????_0???: dop = BSE_OP_RSKIP;
      16'b1001_10?1_????_????: dop = BSE_OP_ISKIP;
      16'b1111_0???_????_????: dop = BSE_OP_BR;
      16'b1001010?????111?: dop = BSE_OP_CALL;
      16'b10010101000?1000: dop = BSE_OP_BACK;
      16'b1001_00??_????_????: begin
        if (w[3:0] == 4'h0) begin
          dop = w[9] ? BSE_OP_DWRITE : BSE_OP_DFETCH;
        end else if (w[3:0] inside {4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he}) begin
          dop = w[9] ? BSE_OP_STP : BSE_OP_LDP;
          pidx = (w[3:2] == 2'b11) ? BSE_PX : (w[3] ? BSE_PY : BSE_PZ);
          ppost = w[1:0] == 2'b01;
          ppre = w[1:0] == 2'b10;
        end
      end
      16'b10?0_????_????_????: begin
        dop = w[9] ? BSE_OP_STP : BSE_OP_LDP;
        pidx = w[3] ? BSE_PY : BSE_PZ;
        q = {w[13], w[11:10], w[2:0]};
      end
      default: ;
    endcase
  end

  // Operands and compare flags
  assign cmp_carry = w[15:10] == 6'b000001;
  assign dd = (w[15:12] == 4'h3) ? {1'b1, w[7:4]} : w[8:4];
  assign rdv = rf_r[dd];
  assign rrv = (w[15:12] == 4'h3) ? {w[11:8], w[3:0]} : rf_r[{w[9], w[3:0]}];
  assign res = rdv - rrv - {7'h00, cmp_carry & flags_r[BSE_FC]};
  assign fh = (~rdv[3] & rrv[3]) | (rrv[3] & res[3]) | (res[3] & ~rdv[3]);
  assign fv = (rdv[7] & ~rrv[7] & ~res[7]) | (~rdv[7] & rrv[7] & res[7]);
  assign fc = (~rdv[7] & rrv[7]) | (rrv[7] & res[7]) | (res[7] & ~rdv[7]);
  // Carry-chained compare can only keep or clear zero, so multi-byte compares work
  assign fz = (res == 8'h00) & (~cmp_carry | flags_r[BSE_FZ]);
  always_comb begin
    flags_nxt = flags_r;
    flags_nxt[BSE_FC] = fc;
    flags_nxt[BSE_FZ] = fz;
    flags_nxt[BSE_FN] = res[7];
    flags_nxt[BSE_FV] = fv;
    flags_nxt[BSE_FS] = res[7] ^ fv;
    flags_nxt[BSE_FH] = fh;
  end

  // Conditions; every named branch is a flag branch on its bit
  assign eqv = rf_r[w[8:4]] == rf_r[{w[9], w[3:0]}];
  assign rbit = rf_r[w[8:4]][w[2:0]] == w[9];
  assign brc = flags_r[w[2:0]] == ~w[10];
  assign skip_len = two_r ? BSE_CYC_SKIP2 : BSE_CYC_SKIP1;
  assign koff = {{9{w[9]}}, w[9:3]};
  assign pval = {rf_r[{pidx[4:1], 1'b1}], rf_r[pidx]};
  assign ea = ppre ? pval - 16'h0001 : pval + {10'h000, q};
  assign pnew = ppost ? pval + 16'h0001 : pval - 16'h0001;
  assign link_pc = pc_r + 16'h0002;

  always_comb begin
    need = BSE_CYC_ONE;
    nacc = 2'd0;
    unique case (dop)
      BSE_OP_EQSKIP: need = eqv ? skip_len : BSE_CYC_ONE;
      BSE_OP_RSKIP: need = rbit ? skip_len : BSE_CYC_ONE;
      BSE_OP_ISKIP: nacc = 2'd1;
      BSE_OP_BR: need = brc ? BSE_CYC_TAKEN : BSE_CYC_ONE;
      BSE_OP_DFETCH: begin
        need = BSE_CYC_DFETCH;
        nacc = 2'd1;
      end
      BSE_OP_LDP: begin
        need = BSE_CYC_LDP;
        nacc = 2'd1;
      end
      BSE_OP_DWRITE: begin
        need = BSE_CYC_DWRITE;
        nacc = 2'd1;
      end
      BSE_OP_STP: begin
        need = BSE_CYC_STP;
        nacc = 2'd1;
      end
      BSE_OP_CALL: begin
        need = BSE_CYC_CALL;
        nacc = 2'd2;
      end
      BSE_OP_BACK: begin
        need = BSE_CYC_BACK;
        nacc = 2'd2;
      end
      BSE_OP_NONE, BSE_OP_CMP: ;
    endcase
  end

  // Next data-space access, first one from decode, second one after a completed access
  assign nidx = state_r == BSE_S_RUN;
  always_comb begin
    nx_addr = ea;
    nx_wd = rf_r[w[8:4]];
    nx_we = 1'b0;
    unique case (dop)
      BSE_OP_DFETCH: nx_addr = k2;
      BSE_OP_DWRITE: begin
        nx_addr = k2;
        nx_we = 1'b1;
      end
      BSE_OP_STP: nx_we = 1'b1;
      BSE_OP_ISKIP: nx_addr = BSE_IO_BASE + {11'h000, w[7:3]};
      BSE_OP_CALL: begin
        nx_addr = nidx ? sp_r - 16'h0001 : sp_r;
        nx_wd = nidx ? link_pc[15:8] : link_pc[7:0];
        nx_we = 1'b1;
      end
      BSE_OP_BACK: nx_addr = nidx ? sp_r + 16'h0002 : sp_r + 16'h0001;
      default: ;
    endcase
  end

  assign acc_fire = dmem_r.valid & dmem_ready & ~nvm_wait_r;
  assign stall = dmem_r.valid & ~acc_fire;
  // I/O skip length is only known once the byte has been read
  always_comb begin
    need_eff = need;
    if (dop == BSE_OP_ISKIP) begin
      need_eff = (acc_fire ? dmem_rdata[w[2:0]] : rbuf_r[w[2:0]]) == w[9] ?
                 skip_len : BSE_CYC_ONE;
    end
  end
  assign fin = (state_r == BSE_S_RUN) & ~stall & (cnt_r + 3'h1 >= need_eff) &
               ((acc_r == nacc) | (acc_fire & (acc_r + 2'd1 == nacc)));

  // Sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= BSE_S_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 3'h0;
      acc_r <= 2'd0;
      tot_r <= 8'h00;
      cyc_last_r <= 8'h00;
      stalled_r <= 1'b0;
    end else begin
      unique case (state_r)
        BSE_S_IDLE: begin
          if (launch) begin
            state_r <= BSE_S_DEC;
            busy_r <= 1'b1;
          end
        end
        BSE_S_DEC: begin
          state_r <= BSE_S_RUN;
          cnt_r <= 3'h0;
          acc_r <= 2'd0;
          tot_r <= 8'h00;
          stalled_r <= 1'b0;
        end
        BSE_S_RUN: begin
          tot_r <= tot_r + 8'h01;
          if (acc_fire) acc_r <= acc_r + 2'd1;
          if (!stall) cnt_r <= cnt_r + 3'h1;
          if (stall) stalled_r <= 1'b1;
          if (fin) begin
            state_r <= BSE_S_IDLE;
            busy_r <= 1'b0;
            cyc_last_r <= tot_r + 8'h01;
          end
        end
      endcase
    end
  end

  // Data-space request, held until ready
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dmem_r <= '0;
      nvm_wait_r <= 1'b0;
      rbuf_r <= 8'h00;
      pop_r <= 16'h0000;
    end else begin
      nvm_wait_r <= 1'b0;
      if (state_r == BSE_S_DEC && nacc != 2'd0) begin
        dmem_r <= '{valid: 1'b1, we: nx_we, addr: nx_addr, wdata: nx_wd};
        nvm_wait_r <= nx_addr >= BSE_NVM_BASE;
      end else if (acc_fire) begin
        rbuf_r <= dmem_rdata;
        if (acc_r == 2'd0) pop_r[15:8] <= dmem_rdata;
        else pop_r[7:0] <= dmem_rdata;
        if (acc_r + 2'd1 < nacc) begin
          dmem_r <= '{valid: 1'b1, we: nx_we, addr: nx_addr, wdata: nx_wd};
          nvm_wait_r <= nx_addr >= BSE_NVM_BASE;
        end else begin
          dmem_r.valid <= 1'b0;
        end
      end
    end
  end

  // Register file: loads and pointer updates at retire, compares write nothing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) rf_r[i] <= 8'h00;
    end else if (fin) begin
      if (dop == BSE_OP_DFETCH || dop == BSE_OP_LDP) rf_r[w[8:4]] <= rbuf_r;
      if ((dop == BSE_OP_LDP || dop == BSE_OP_STP) && (ppost || ppre)) begin
        rf_r[pidx] <= pnew[7:0];
        rf_r[{pidx[4:1], 1'b1}] <= pnew[15:8];
      end
    end else if (wr && paddr[11:7] == BSE_OFF_REGS[11:7]) begin
      rf_r[paddr[6:2]] <= pwdata[7:0];
    end
  end

  always_comb begin
    pc_nxt = pc_r + 16'h0001;
    unique case (dop)
      BSE_OP_EQSKIP, BSE_OP_RSKIP, BSE_OP_ISKIP: pc_nxt = pc_r + {13'h0000, need_eff};
      BSE_OP_BR: pc_nxt = brc ? pc_r + koff + 16'h0001 : pc_r + 16'h0001;
      BSE_OP_DFETCH, BSE_OP_DWRITE: pc_nxt = pc_r + 16'h0002;
      BSE_OP_CALL: pc_nxt = k2;
      BSE_OP_BACK: pc_nxt = pop_r;
      default: ;
    endcase
  end

  // Program counter, stack pointer, flags, skip-length hint
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc_r <= BSE_PC_RST;
      sp_r <= BSE_SP_RST;
      flags_r <= BSE_FLAGS_RST;
      two_r <= 1'b0;
    end else if (fin) begin
      pc_r <= pc_nxt;
      if (dop == BSE_OP_CMP) flags_r <= flags_nxt;
      if (dop == BSE_OP_CALL) sp_r <= sp_r - 16'h0002;
      if (dop == BSE_OP_BACK) begin
        sp_r <= sp_r + 16'h0002;
        if (w[4]) flags_r[BSE_FI] <= 1'b1;
      end
    end else if (wr) begin
      if (paddr == BSE_OFF_PC) pc_r <= pwdata[15:0];
      if (paddr == BSE_OFF_SP) sp_r <= pwdata[15:0];
      if (paddr == BSE_OFF_FLAGS) flags_r <= pwdata[7:0];
      if (paddr == BSE_OFF_CFG) two_r <= pwdata[0];
    end
  end

  // APB slave, one wait state; engine state cannot be written while an instruction runs
  assign eng_reg = paddr == BSE_OFF_INSTR || paddr == BSE_OFF_CFG || paddr == BSE_OFF_FLAGS ||
                   paddr == BSE_OFF_PC || paddr == BSE_OFF_SP || paddr[11:7] == 5'h01;
  assign hit = eng_reg || paddr == BSE_OFF_STAT;
  assign err = ~hit | (pwrite & busy_r & eng_reg);
  assign wr = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign launch = wr && paddr == BSE_OFF_INSTR;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr[11:7] == 5'h01) rd_val = {24'h000000, rf_r[paddr[6:2]]};
    else if (paddr == BSE_OFF_INSTR) rd_val = instr_r;
    else if (paddr == BSE_OFF_CFG) rd_val = {31'h00000000, two_r};
    else if (paddr == BSE_OFF_FLAGS) rd_val = {24'h000000, flags_r};
    else if (paddr == BSE_OFF_PC) rd_val = {16'h0000, pc_r};
    else if (paddr == BSE_OFF_SP) rd_val = {16'h0000, sp_r};
    else if (paddr == BSE_OFF_STAT) rd_val = {16'h0000, cyc_last_r, 7'h00, busy_r};
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      instr_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & err;
      prdata_r <= (psel & penable & ~pready_r & ~pwrite & hit) ? rd_val : 32'h0000_0000;
      if (launch) instr_r <= pwdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_eq_skip;
    fin && dop == BSE_OP_EQSKIP && eqv && !two_r |=> pc_r == $past(pc_r) + 16'h0002;
  endproperty
  a_eq_skip: assert property (p_eq_skip) else $error("equal skip advance wrong");
  property p_rskip_flags;
    fin && dop == BSE_OP_RSKIP |=> $stable(flags_r);
  endproperty
  a_rskip_flags: assert property (p_rskip_flags) else $error("bit skip changed flags");
  property p_br_cycles;
    fin && dop == BSE_OP_BR |-> tot_r == (brc ? 8'h01 : 8'h00);
  endproperty
  a_br_cycles: assert property (p_br_cycles) else $error("branch cycle count wrong");
  property p_carry_br;
    fin && dop == BSE_OP_BR && w[2:0] == 3'h0 && !w[10] && flags_r[BSE_FC]
      |=> pc_r == $past(pc_r) + $past(koff) + 16'h0001;
  endproperty
  a_carry_br: assert property (p_carry_br) else $error("carry branch target wrong");
  property p_dfetch_cycles;
    fin && dop == BSE_OP_DFETCH && !stalled_r && !stall |-> tot_r == 8'h02;
  endproperty
  a_dfetch_cycles: assert property (p_dfetch_cycles) else $error("direct load not 3 cycles");
  property p_post_inc;
    fin && dop == BSE_OP_LDP && ppost && pidx != w[8:4] && pidx + 5'h01 != w[8:4]
      |=> pval == $past(pval) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment missing");
  property p_pre_dec_addr;
    state_r == BSE_S_RUN && dmem_r.valid && dop == BSE_OP_LDP && ppre
      |-> dmem_r.addr == pval - 16'h0001;
  endproperty
  a_pre_dec_addr: assert property (p_pre_dec_addr) else $error("pre decrement address");
  property p_dwrite_addr;
    state_r == BSE_S_RUN && dmem_r.valid && dop == BSE_OP_DWRITE
      |-> dmem_r.we && dmem_r.addr == k2;
  endproperty
  a_dwrite_addr: assert property (p_dwrite_addr) else $error("direct store address wrong");
  property p_stp_one;
    fin && dop == BSE_OP_STP && !stalled_r |-> tot_r == 8'h00;
  endproperty
  a_stp_one: assert property (p_stp_one) else $error("pointer store not 1 cycle");
  property p_nvm_wait;
    $rose(dmem_r.valid) && dmem_r.addr >= BSE_NVM_BASE |=> dmem_r.valid;
  endproperty
  a_nvm_wait: assert property (p_nvm_wait) else $error("nvm access too fast");
  property p_call;
    fin && dop == BSE_OP_CALL |=> pc_r == $past(k2) && sp_r == $past(sp_r) - 16'h0002;
  endproperty
  a_call: assert property (p_call) else $error("call result wrong");

  c_skip3: cover property (fin && dop == BSE_OP_EQSKIP && need_eff == BSE_CYC_SKIP2);
  c_br_taken: cover property (fin && dop == BSE_OP_BR && brc);
  c_back: cover property (fin && dop == BSE_OP_BACK && w[4]);
  c_nvm: cover property (fin && dop == BSE_OP_DFETCH && stalled_r);
endmodule

// ### dv/bse_dmem_model.sv
/*
  Data space model: byte memory with a settable ready delay per access.
  Assumes requests are held until ready, on the engine's clock.
*/
`timescale 1ns/1ps
module bse_dmem_model
  import bse_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire bse_dreq_t dmem_req,
  input wire logic [7:0] stall,
  output logic [7:0] dmem_rdata,
  output logic dmem_ready
);
  logic [7:0] mem [0:8191];
  logic [7:0] wait_r;
  logic [7:0] last_r;
  assign dmem_ready = dmem_req.valid && wait_r >= stall;
  // Not answering: drive the inverse so stale data never matches
  assign dmem_rdata = dmem_ready ? mem[dmem_req.addr[12:0]] : ~last_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_r <= 8'h00;
      last_r <= 8'h00;
    end else if (dmem_ready) begin
      wait_r <= 8'h00;
      last_r <= dmem_rdata;
    end else if (dmem_req.valid) begin
      wait_r <= wait_r + 8'h01;
    end
  end
  always @(posedge clk_sys) begin
    if (dmem_ready && dmem_req.we) begin
      mem[dmem_req.addr[12:0]] <= dmem_req.wdata;
    end
  end
endmodule

// ### dv/branch_skip_load_store_exec_tb.sv
/*
  Self-checking bench: APB master, data space model, expected values from ints.
  Assumes the engine's one-wait-state APB and its run-cycle counts in STAT.
*/
`timescale 1ns/1ps
module branch_skip_load_store_exec_tb
  import bse_pkg::*;
;
  logic clk_sys = 0;
  logic reset = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, exec_busy, dmem_ready, erv;
  bse_dreq_t dmem_req;
  logic [7:0] dmem_rdata;
  logic [7:0] stall = 8'h00;
  logic [31:0] rdv;
  logic [15:0] op;
  logic [15:0] opt [9] = '{16'h900c, 16'h900d, 16'h900e, 16'h8008, 16'h9009, 16'h900a,
    16'h8000, 16'h9001, 16'h9002};
  int miscompares = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  int seed = 98;
  int i, a, b, c, f, k, p, m, pc0, sp0, ptr, ad, v, t;
  always #5 clk_sys = ~clk_sys;
  bse_exec dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .dmem_ready(dmem_ready), .exec_busy(exec_busy));
  bse_dmem_model mem_u (.clk_sys(clk_sys), .reset(reset), .dmem_req(dmem_req),
    .stall(stall), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] ad_i, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad_i;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // No fixed wait: only the bench timeout ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] ad_i, input int d);
    apb(1'h1, ad_i, d);
  endtask
  task automatic rd(input logic [11:0] ad_i);
    apb(1'h0, ad_i, 32'h0);
  endtask
  function automatic logic [11:0] ra(input int n);
    return BSE_OFF_REGS + 12'(4 * n);
  endfunction
  task automatic go(input logic [15:0] o, input int kk);
    wr(BSE_OFF_INSTR, {kk[15:0], o});
  endtask
  // Busy rises one edge after the write, so skip two edges first
  task automatic fin(input int cy);
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (exec_busy !== 1'h0 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(exec_busy, 0);
    rd(BSE_OFF_STAT);
    chk(rdv[15:8], cy);
  endtask
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'h0;
    rd(BSE_OFF_SP);
    chk(rdv, 32'hff);
    rd(12'h040);
    chk(erv, 1);
    chk(rdv, 0);
    wr(BSE_OFF_STAT, 5);
    chk(erv, 0);
    for (i = 0; i < 32; i++) begin
      f = rnd() & 32'hef;
      f = f | (f >> 2 ^ f >> 3) << 4 & 32'h10;
      k = rnd() & 32'h7f;
      pc0 = rnd() & 32'hffff;
      wr(BSE_OFF_FLAGS, f);
      wr(BSE_OFF_PC, pc0);
      t = f[i % 8] ^ (i / 8 % 2);
      go(16'hf000 | 16'((i / 8 % 2) << 10 | k << 3 | i % 8), 0);
      fin(t ? 2 : 1);
      rd(BSE_OFF_PC);
      chk(rdv, (pc0 + 1 + (t ? k - (k[6] ? 128 : 0) : 0)) & 32'hffff);
      rd(BSE_OFF_FLAGS);
      chk(rdv, f);
    end
    for (i = 0; i < 20; i++) begin
      c = i / 5 % 2;
      wr(BSE_OFF_CFG, c);
      a = rnd() % 32;
      b = rnd() % 8;
      v = rnd() & 32'hff;
      pc0 = rnd() & 32'hffff;
      wr(BSE_OFF_PC, pc0);
      setr_blk: begin
        wr(ra(a), v);
      end
      case (i % 5)
        0: begin
          p = rnd() % 32;
          m = rnd() % 2 ? v : rnd() & 32'hff;
          wr(ra(p), m);
          t = p == a || m == v;
          op = 16'h1000 | 16'(a << 4 | p & 15 | (p & 16) << 5);
        end
        1, 2: begin
          t = v[b] == (i % 5 == 2);
          op = 16'hfc00 | 16'((i % 5 - 1) << 9 | a << 4 | b);
        end
        default: begin
          mem_u.mem[a] = 8'(v);
          t = v[b] == (i % 5 == 4);
          op = 16'h9900 | 16'((i % 5 - 3) << 9 | a << 3 | b);
        end
      endcase
      go(op, 0);
      fin(t ? 2 + c : 1);
      rd(BSE_OFF_PC);
      chk(rdv, (pc0 + (t ? 2 + c : 1)) & 32'hffff);
    end
    wr(BSE_OFF_CFG, 0);
    for (i = 0; i < 12; i++) begin
      a = 16 + rnd() % 16;
      p = rnd() % 32;
      v = rnd() & 32'hff;
      k = rnd() & 32'hff;
      f = rnd() & 32'hff;
      wr(ra(p), k);
      wr(ra(a), v);
      wr(BSE_OFF_FLAGS, f);
      case (i % 3)
        0: op = 16'h1400 | 16'(a << 4 | p & 15 | (p & 16) << 5);
        1: op = 16'h0400 | 16'(a << 4 | p & 15 | (p & 16) << 5);
        default: op = 16'h3000 | 16'((k & 240) << 4 | (a & 15) << 4 | k & 15);
      endcase
      if (p == a && i % 3 != 2) k = v;
      c = i % 3 == 1 ? f & 1 : 0;
      m = (v - k - c) & 32'hff;
      b = ~v & k | k & m | m & ~v;
      t = (v & ~k & ~m | ~v & k & m) >> 7 & 1;
      ad = f & 32'hc0 | (b >> 3 & 1) << 5 | (m >> 7 ^ t) << 4 | t << 3 | m >> 7 << 2;
      ad = ad | (m == 0 && (i % 3 != 1 || f & 2)) << 1 | b >> 7 & 1;
      go(op, 0);
      fin(1);
      rd(BSE_OFF_FLAGS);
      chk(rdv, ad);
      rd(ra(a));
      chk(rdv, v);
    end
    for (i = 0; i < 24; i++) begin
      m = i % 4;
      p = m == 3 ? 1 + i % 2 : i % 3;
      a = rnd() % 26;
      v = rnd() & 32'hff;
      ptr = (i % 5 == 0 ? 32'h1000 : 32'h0100) + rnd() % 256 + 1;
      k = m == 3 ? rnd() % 64 : 0;
      t = i / 4 % 2;
      stall <= 8'(i / 8);
      wr(ra(26 + 2 * p), ptr & 32'hff);
      wr(ra(27 + 2 * p), ptr >> 8);
      wr(ra(a), v);
      ad = m == 2 ? ptr - 1 : ptr + k;
      op = m == 3 ? opt[3 * p] | 16'((k & 32) << 8 | (k & 24) << 7 | k & 7) : opt[3 * p + m];
      op = op | 16'(a << 4 | t << 9);
      mem_u.mem[ad] = 8'(v ^ 90);
      c = i / 8;
      if (ad >= 32'h1000 && c == 0) c = 1;
      go(op, 0);
      fin(2 - t + c);
      rd(ra(a));
      chk(t ? mem_u.mem[ad] : rdv[7:0], t ? v : v ^ 90);
      rd(ra(26 + 2 * p));
      c = rdv[7:0];
      rd(ra(27 + 2 * p));
      chk({rdv[7:0], c[7:0]}, m == 1 ? ptr + 1 : m == 2 ? ptr - 1 : ptr);
    end
    stall <= 8'h00;
    for (i = 0; i < 2; i++) begin
      a = rnd() % 32;
      v = rnd() & 32'hff;
      wr(ra(a), v);
      mem_u.mem[32'h0300 + i] = 8'(v ^ 90);
      go(16'h9000 | 16'(a << 4 | i << 9), 32'h0300 + i);
      fin(3 - i);
      rd(ra(a));
      chk(i ? mem_u.mem[32'h0300 + i] : rdv[7:0], i ? v : v ^ 90);
      pc0 = rnd() & 32'hffff;
      sp0 = 32'h0400 + rnd() % 256;
      k = rnd() & 32'hffff;
      wr(BSE_OFF_PC, pc0);
      wr(BSE_OFF_SP, sp0);
      wr(BSE_OFF_FLAGS, 0);
      go(16'h940e, k);
      fin(3);
      rd(BSE_OFF_PC);
      chk(rdv, k);
      chk({mem_u.mem[sp0 - 1], mem_u.mem[sp0]}, (pc0 + 2) & 32'hffff);
      go(16'h9508 | 16'(i << 4), 0);
      fin(4);
      rd(BSE_OFF_PC);
      chk(rdv, (pc0 + 2) & 32'hffff);
      rd(BSE_OFF_SP);
      chk(rdv, sp0);
      rd(BSE_OFF_FLAGS);
      chk(rdv, i << 7);
    end
    // Slow data space keeps the engine busy while a second start is tried
    stall <= 8'h28;
    go(16'h9000, 32'h0300);
    go(16'h0000, 0);
    chk(erv, 1);
    fin(43);
    finish_test();
  end
endmodule
